// >>> hdl/supply_and_pushbutton_reset_oneshot.sv
// Reset sequencer combining a supply fault and a one-shot debounced pushbutton reset
`timescale 1ns/1ps
module supply_and_pushbutton_reset_oneshot #(
    parameter logic TIMEOUT_OPTION = rst_seq_pkg::SHORT_TIMEOUT_OPTION,
    parameter logic OUTPUT_STYLE = rst_seq_pkg::OUTPUT_PUSH_PULL,
    parameter int unsigned SUPPLY_SHORT_CYCLES = rst_seq_pkg::SUPPLY_SHORT_MIN_MS * rst_seq_pkg::CLK_PER_MS,
    parameter int unsigned SUPPLY_LONG_CYCLES = rst_seq_pkg::SUPPLY_LONG_MIN_MS * rst_seq_pkg::CLK_PER_MS,
    parameter int unsigned MANUAL_PULSE_CYCLES = rst_seq_pkg::MANUAL_PULSE_MIN_MS * rst_seq_pkg::CLK_PER_MS,
    parameter int unsigned DEBOUNCE_CYCLES = rst_seq_pkg::DEBOUNCE_MIN_MS * rst_seq_pkg::CLK_PER_MS
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Monitored conditions
    input wire logic i_supply_below_threshold,
    input wire logic i_manual_reset_request_n,
    // Reset output pin as two signals, plus two status flags
    output logic o_reset_n,
    output logic o_reset_n_oe,
    output logic o_supply_reset_active,
    output logic o_manual_pulse_active
);
    // Counts less one, since expiry is seen a cycle after zero is reached
    localparam logic [rst_seq_pkg::CNT_W-1:0] SUPPLY_LOAD =
        rst_seq_pkg::CNT_W'((TIMEOUT_OPTION == rst_seq_pkg::LONG_TIMEOUT_OPTION) ?
        SUPPLY_LONG_CYCLES - 1 : SUPPLY_SHORT_CYCLES - 1);
    localparam logic [rst_seq_pkg::CNT_W-1:0] MANUAL_LOAD = rst_seq_pkg::CNT_W'(MANUAL_PULSE_CYCLES - 1);
    localparam logic [rst_seq_pkg::CNT_W-1:0] DEBOUNCE_LOAD = rst_seq_pkg::CNT_W'(DEBOUNCE_CYCLES - 1);

    ms_timer_if supply_tmr ();
    ms_timer_if manual_tmr ();

    ms_timer u_supply_timer (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .tmr(supply_tmr)
    );
    ms_timer u_manual_timer (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .tmr(manual_tmr)
    );

    logic supply_active;
    logic supply_start;
    logic manual_prev;
    logic manual_fall;
    logic manual_rise;
    rst_seq_pkg::manual_state_t mstate;
    rst_seq_pkg::manual_state_t next_mstate;

    // Pulse decode shared by the pin, its enable, the status flag and the checks
    function automatic logic is_pulse(input rst_seq_pkg::manual_state_t s);
        return s == rst_seq_pkg::MAN_PULSE;
    endfunction

    // First cycle out of reset starts the power-up timeout, as if the supply had just recovered.
    // Without it the timer would sit at zero and drop the power-up fault at once.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            supply_start <= 1'b1;
        end else begin
            supply_start <= 1'b0;
        end
    end

    // Manual input edges; the input is taken as already synchronous
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            manual_prev <= 1'b1;
        end else begin
            manual_prev <= i_manual_reset_request_n;
        end
    end
    assign manual_fall = manual_prev && !i_manual_reset_request_n;
    assign manual_rise = !manual_prev && i_manual_reset_request_n;

    // Supply timer reloads every cycle the supply is low, so the timeout starts at recovery
    assign supply_tmr.load = i_supply_below_threshold || supply_start;
    assign supply_tmr.load_value = SUPPLY_LOAD;
    assign supply_tmr.run = supply_active;

    // Supply fault flag: set at once, cleared only after the full timeout
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            supply_active <= 1'b1; // Power-up counts as a supply fault
        end else if (i_supply_below_threshold) begin
            supply_active <= 1'b1;
        end else if (supply_tmr.done) begin
            supply_active <= 1'b0;
        end
    end

    // One-shot sequencing
    always_comb begin
        next_mstate = mstate;
        case (mstate)
            rst_seq_pkg::MAN_ARMED: begin
                if (manual_fall) begin
                    next_mstate = rst_seq_pkg::MAN_PULSE;
                end
            end
            rst_seq_pkg::MAN_PULSE: begin
                // Falling edges here are ignored
                if (manual_tmr.done) begin
                    next_mstate = i_manual_reset_request_n ? rst_seq_pkg::MAN_DEBOUNCE : rst_seq_pkg::MAN_WAIT_HIGH;
                end else if (manual_rise) begin
                    next_mstate = rst_seq_pkg::MAN_PULSE;
                end
            end
            rst_seq_pkg::MAN_WAIT_HIGH: begin
                // Input held low past the pulse: pulse is not extended
                if (i_manual_reset_request_n) begin
                    next_mstate = rst_seq_pkg::MAN_DEBOUNCE;
                end
            end
            rst_seq_pkg::MAN_DEBOUNCE: begin
                if (!i_manual_reset_request_n) begin
                    next_mstate = rst_seq_pkg::MAN_WAIT_HIGH;
                end else if (manual_tmr.done) begin
                    next_mstate = rst_seq_pkg::MAN_ARMED;
                end
            end
            default: begin
                next_mstate = rst_seq_pkg::MAN_ARMED;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            mstate <= rst_seq_pkg::MAN_ARMED;
        end else begin
            mstate <= next_mstate;
        end
    end

    // Manual timer loads on the firing edge and on every high-going start of debounce
    always_comb begin
        manual_tmr.load = 1'b0;
        manual_tmr.load_value = MANUAL_LOAD;
        if (mstate == rst_seq_pkg::MAN_ARMED && manual_fall) begin
            manual_tmr.load = 1'b1;
        end else if (next_mstate == rst_seq_pkg::MAN_DEBOUNCE && mstate != rst_seq_pkg::MAN_DEBOUNCE) begin
            manual_tmr.load = 1'b1;
            manual_tmr.load_value = DEBOUNCE_LOAD;
        end
    end
    assign manual_tmr.run = (mstate == rst_seq_pkg::MAN_PULSE) || (mstate == rst_seq_pkg::MAN_DEBOUNCE);

    // Registered outputs; combining both sources trades one cycle of latency for glitch-free pins
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_reset_n <= 1'b0;
            o_reset_n_oe <= 1'b1;
            o_supply_reset_active <= 1'b1;
            o_manual_pulse_active <= 1'b0;
        end else begin
            // The raw supply flag is folded in so the pin falls one cycle after a fault is seen
            o_reset_n <= !(i_supply_below_threshold || supply_active || is_pulse(mstate));
            // Open-drain only drives while low
            o_reset_n_oe <= (OUTPUT_STYLE == rst_seq_pkg::OUTPUT_PUSH_PULL) ||
                (i_supply_below_threshold || supply_active || is_pulse(mstate));
            o_supply_reset_active <= supply_active;
            o_manual_pulse_active <= is_pulse(mstate);
        end
    end

    // Checks
    int unsigned high_run;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || !i_manual_reset_request_n) begin
            high_run <= 0;
        end else if (high_run < DEBOUNCE_CYCLES + 2) begin
            high_run <= high_run + 1;
        end
    end

    // Length of the running one-shot, in cycles spent in the pulse state
    int unsigned pulse_len;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || !is_pulse(mstate)) begin
            pulse_len <= 0;
        end else if (pulse_len < MANUAL_PULSE_CYCLES + 2) begin
            pulse_len <= pulse_len + 1;
        end
    end

    // Cycles the fault flag has stood since the supply came back; saturates so it cannot wrap
    localparam int unsigned SUPPLY_CYCLES = (TIMEOUT_OPTION == rst_seq_pkg::LONG_TIMEOUT_OPTION) ?
        SUPPLY_LONG_CYCLES : SUPPLY_SHORT_CYCLES;
    int unsigned recover_len;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || supply_start || i_supply_below_threshold || !supply_active) begin
            recover_len <= 0;
        end else if (recover_len < SUPPLY_CYCLES + 2) begin
            recover_len <= recover_len + 1;
        end
    end

    AST_PULSE_LENGTH: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $fell(mstate == rst_seq_pkg::MAN_PULSE) |-> pulse_len == MANUAL_PULSE_CYCLES)
        else $error("manual pulse length wrong");
    AST_RECOVER_LENGTH: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $fell(supply_active) |-> recover_len == SUPPLY_CYCLES)
        else $error("supply timeout length wrong");
    AST_WAIT_NO_FIRE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (mstate == rst_seq_pkg::MAN_WAIT_HIGH) |=> mstate != rst_seq_pkg::MAN_PULSE)
        else $error("fired while input held");
    AST_FLAG_SET: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_supply_below_threshold |=> supply_active)
        else $error("fault flag not set");
    AST_STATUS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        1'b1 |=> (o_supply_reset_active == $past(supply_active)) &&
        (o_manual_pulse_active == $past(mstate == rst_seq_pkg::MAN_PULSE)))
        else $error("status flags out of step");

    AST_SUPPLY_LOW: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_supply_below_threshold |=> !o_reset_n) else $error("reset not low during supply fault");
    AST_SUPPLY_HOLD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $fell(i_supply_below_threshold) |=> !o_reset_n [*8]) else $error("reset released early");
    AST_MANUAL_FIRE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (mstate == rst_seq_pkg::MAN_ARMED && manual_fall) |=> ##1 !o_reset_n) else $error("no manual pulse");
    AST_PULSE_STAYS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (mstate == rst_seq_pkg::MAN_PULSE && manual_fall) |=> mstate == rst_seq_pkg::MAN_PULSE || $past(manual_tmr.done))
        else $error("edge disturbed pulse");
    AST_DEBOUNCE_IGNORE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (mstate == rst_seq_pkg::MAN_DEBOUNCE && manual_fall) |=> mstate != rst_seq_pkg::MAN_PULSE)
        else $error("fired inside debounce");
    AST_REARM: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $rose(mstate == rst_seq_pkg::MAN_ARMED) |-> high_run >= DEBOUNCE_CYCLES) else $error("rearmed early");
    AST_RELEASE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $rose(o_reset_n) |-> $past(!supply_active && mstate != rst_seq_pkg::MAN_PULSE))
        else $error("released while a source active");
    AST_OPEN_DRAIN: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (OUTPUT_STYLE == rst_seq_pkg::OUTPUT_OPEN_DRAIN) |-> (o_reset_n_oe == !o_reset_n))
        else $error("open-drain drives high");
    AST_IDLE_HIGH: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (mstate == rst_seq_pkg::MAN_ARMED && i_manual_reset_request_n) |=> mstate == rst_seq_pkg::MAN_ARMED)
        else $error("high input fired");

    COV_SUPPLY: cover property (@(posedge i_mclk) disable iff (!i_resetn) $fell(o_supply_reset_active));
    COV_MANUAL: cover property (@(posedge i_mclk) disable iff (!i_resetn) $fell(o_manual_pulse_active));
    COV_BOUNCE: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        mstate == rst_seq_pkg::MAN_DEBOUNCE && manual_fall);
    COV_REARM: cover property (@(posedge i_mclk) disable iff (!i_resetn) $rose(mstate == rst_seq_pkg::MAN_ARMED));
    COV_HELD: cover property (@(posedge i_mclk) disable iff (!i_resetn) mstate == rst_seq_pkg::MAN_WAIT_HIGH);
endmodule // supply_and_pushbutton_reset_oneshot

// >>> hdl/rst_seq_pkg.sv
// Constants for the supply and pushbutton reset sequencer
package rst_seq_pkg;
    // Clock
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    // Timing in milliseconds: least times round up, so counts use the minimum figures
    localparam int unsigned SUPPLY_SHORT_MIN_MS = 150;
    localparam int unsigned SUPPLY_SHORT_MAX_MS = 300;
    localparam int unsigned SUPPLY_LONG_MIN_MS = 1200;
    localparam int unsigned SUPPLY_LONG_MAX_MS = 2400;
    localparam int unsigned MANUAL_PULSE_MIN_MS = 150;
    localparam int unsigned MANUAL_PULSE_MAX_MS = 300;
    localparam int unsigned DEBOUNCE_MIN_MS = 150;
    localparam int unsigned DEBOUNCE_MAX_MS = 300;
    // Option encoding
    localparam logic SHORT_TIMEOUT_OPTION = 1'b0;
    localparam logic LONG_TIMEOUT_OPTION = 1'b1;
    // Output style
    localparam logic OUTPUT_OPEN_DRAIN = 1'b0;
    localparam logic OUTPUT_PUSH_PULL = 1'b1;
    // Counter width, large enough for the long timeout
    localparam int unsigned CNT_W = 32;
    // Manual one-shot states
    typedef enum logic [1:0] {
        MAN_ARMED = 2'b00,
        MAN_PULSE = 2'b01,
        MAN_WAIT_HIGH = 2'b10,
        MAN_DEBOUNCE = 2'b11
    } manual_state_t;
endpackage

// >>> hdl/ms_timer_if.sv
// Interface carrying a load or run request and its expiry from a down-counter
`timescale 1ns/1ps
interface ms_timer_if;
    logic load;
    logic [rst_seq_pkg::CNT_W-1:0] load_value;
    logic run;
    logic done;
    modport owner (output load, output load_value, output run, input done);
    modport timer (input load, input load_value, input run, output done);
endinterface

// >>> hdl/ms_timer.sv
// Loadable down-counter that flags expiry
`timescale 1ns/1ps
module ms_timer (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Control
    ms_timer_if.timer tmr
);
    logic [rst_seq_pkg::CNT_W-1:0] count;

    // Load wins over counting; done is high while the count is zero and not reloaded
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            count <= '0;
        end else if (tmr.load) begin
            count <= tmr.load_value;
        end else if (tmr.run && count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign tmr.done = (count == '0) && !tmr.load;
endmodule // ms_timer

// >>> verif/pushbutton_and_reset_load.sv
// Far-side model: pushbutton with pull-up and the reset line with its pull-up
`timescale 1ns/1ps
module pushbutton_and_reset_load (
    // Command from the bench
    input wire logic i_press,
    // Reset pin from the sequencer
    input wire logic i_reset_n,
    input wire logic i_reset_n_oe,
    // Resolved lines
    output logic o_manual_n,
    output logic o_reset_line
);
    // Button shorts the input to ground; released or unwired, the pull-up holds it high
    assign o_manual_n = i_press ? 1'b0 : 1'b1;
    // An undriven pin floats up through the external pull-up, never to the last value
    assign o_reset_line = i_reset_n_oe ? i_reset_n : 1'b1;
endmodule // pushbutton_and_reset_load

// >>> verif/tb_supply_and_pushbutton_reset_oneshot.sv
// Self-checking testbench for the supply and pushbutton reset sequencer
`timescale 1ns/1ps
module tb_supply_and_pushbutton_reset_oneshot;
    localparam int SUP = 20;
    localparam int MAN = 10;
    localparam int DEB = 12;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_supply_below_threshold = 1'b0;
    logic press = 1'b0;
    logic manual_n, o_reset_n, o_reset_n_oe, o_supply_reset_active, o_manual_pulse_active, reset_line;
    int n_mismatch = 0;
    int checked = 0;
    int n;
    // Clock at 200 MHz
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    // Open-drain build so the enable is exercised; short counts keep the run brief
    supply_and_pushbutton_reset_oneshot #(.TIMEOUT_OPTION(rst_seq_pkg::SHORT_TIMEOUT_OPTION),
        .OUTPUT_STYLE(rst_seq_pkg::OUTPUT_OPEN_DRAIN), .SUPPLY_SHORT_CYCLES(SUP), .SUPPLY_LONG_CYCLES(40),
        .MANUAL_PULSE_CYCLES(MAN), .DEBOUNCE_CYCLES(DEB)) supply_and_pushbutton_reset_oneshot_inst (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_supply_below_threshold(i_supply_below_threshold),
        .i_manual_reset_request_n(manual_n), .o_reset_n(o_reset_n), .o_reset_n_oe(o_reset_n_oe),
        .o_supply_reset_active(o_supply_reset_active), .o_manual_pulse_active(o_manual_pulse_active));
    pushbutton_and_reset_load pushbutton_and_reset_load_inst (.i_press(press), .i_reset_n(o_reset_n),
        .i_reset_n_oe(o_reset_n_oe), .o_manual_n(manual_n), .o_reset_line(reset_line));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // Counts falling edges of the clock until the reset line is released, bounded
    task automatic low_len(output int len);
        len = 0;
        while (reset_line !== 1'b1) begin
            @(negedge i_mclk);
            len++;
            if (len > 300) begin
                check(1'b0, "reset never released");
                close_out();
            end
        end
    endtask
    // Reset line must stay released for k cycles
    task automatic idle_high(input int k, input string msg);
        bit bad;
        bad = 0;
        repeat (k) begin
            @(negedge i_mclk);
            if (reset_line !== 1'b1 || o_reset_n_oe !== 1'b0) bad = 1;
        end
        check(!bad, msg);
    endtask
    task automatic power_up();
        low_len(n);
        check(n >= SUP && n <= SUP + 4, "power-up timeout length");
        idle_high(30, "reset with input unwired");
    endtask
    task automatic supply_dip();
        i_supply_below_threshold = 1'b1;
        @(negedge i_mclk);
        check(reset_line === 1'b0 && o_reset_n_oe === 1'b1, "no reset on low supply");
        repeat (30) @(negedge i_mclk);
        check(reset_line === 1'b0 && o_supply_reset_active === 1'b1, "released while supply low");
        i_supply_below_threshold = 1'b0;
        low_len(n);
        check(n >= SUP && n <= SUP + 4, "recovery timeout length");
    endtask
    task automatic manual_held();
        press = 1'b1;
        repeat (2) @(negedge i_mclk);
        check(reset_line === 1'b0 && o_manual_pulse_active === 1'b1, "no manual pulse");
        low_len(n);
        check(n + 2 >= MAN - 1 && n + 2 <= MAN + 2, "manual pulse length");
        idle_high(25, "pulse repeated while held");
        press = 1'b0;
        idle_high(DEB + 4, "reset on release");
    endtask
    task automatic manual_bounce();
        press = 1'b1;
        repeat (4) @(negedge i_mclk);
        press = 1'b0;
        @(negedge i_mclk);
        press = 1'b1;
        low_len(n);
        check(n + 5 >= MAN - 1 && n + 5 <= MAN + 2, "pulse stretched by bounce");
        press = 1'b0;
        repeat (3) @(negedge i_mclk);
        press = 1'b1;
        idle_high(6, "edge inside debounce accepted");
        press = 1'b0;
        repeat (DEB + 3) @(negedge i_mclk);
        press = 1'b1;
        repeat (2) @(negedge i_mclk);
        check(reset_line === 1'b0, "one-shot did not rearm");
        low_len(n);
        press = 1'b0;
        repeat (DEB + 3) @(negedge i_mclk);
    endtask
    task automatic both_sources();
        press = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_supply_below_threshold = 1'b1;
        repeat (MAN + 6) @(negedge i_mclk);
        check(reset_line === 1'b0, "released while supply low after pulse");
        i_supply_below_threshold = 1'b0;
        low_len(n);
        check(n >= SUP && n <= SUP + 4, "combined release timing");
        press = 1'b0;
        repeat (DEB + 3) @(negedge i_mclk);
    endtask
    // Main sequence: reset for 20 cycles, then each scenario in turn
    initial begin
        repeat (20) @(negedge i_mclk);
        i_resetn = 1'b1;
        power_up();
        supply_dip();
        manual_held();
        manual_bounce();
        both_sources();
        close_out();
    end
endmodule // tb_supply_and_pushbutton_reset_oneshot
